/* logic/pcs_config_target.sv */
// Purpose: configuration-cycle target for a network controller
// Assumes: bus signals are synchronous to ref_clk, one data phase
// Notes: burst attempts are disconnected after the first data phase
`timescale 1ns/1ps
module pcs_config_target
  import pcs_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = 16'h1D1D, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0A0A, // arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h01 // arbitrary value
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request side from the host bridge
  input wire logic frameN,
  input wire logic irdyN,
  input wire logic idsel,
  input wire logic [pcs_pkg::CBE_W-1:0] cbeN,
  input wire logic [pcs_pkg::AD_W-1:0] adIn,
  // address/data and parity answer
  output logic [pcs_pkg::AD_W-1:0] adOut,
  output logic adOeN,
  output logic parOut,
  output logic parOeN,
  // target control answer
  output logic devselN,
  output logic devselOeN,
  output logic trdyN,
  output logic trdyOeN,
  output logic stopN,
  output logic stopOeN,
  // setting used by the bus master logic
  output logic [7:0] cacheLineUse
);
  import pcs_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pcs_state_t state_r;
  pcs_state_t state_nxt;
  logic frameNPrev_r;
  logic [DW_IDX_W-1:0] dwordIdx_r;
  logic isWrite_r;
  logic [7:0] cacheLine_r;
  logic [7:0] cacheLineUse_r;
  logic [AD_W-1:0] adOut_r;
  logic [AD_W-1:0] adOut_nxt;
  logic adOeN_r;
  logic adOeN_nxt;
  logic parOut_r;
  logic parOeN_r;
  logic devselN_r;
  logic devselN_nxt;
  logic ctlOeN_r;
  logic ctlOeN_nxt;
  logic trdyN_r;
  logic trdyN_nxt;
  logic stopN_r;
  logic stopN_nxt;

  // ---------------------------------------------------------------
  // address phase decode
  // ---------------------------------------------------------------
  wire logic addrPhase;
  wire logic isCfgCmd;
  wire logic isType0;
  wire logic isFunc0;
  wire logic claimHit;
  wire logic cmdIsWrite;
  // an address phase is the first cycle with frame low after idle
  assign addrPhase = frameNPrev_r & ~frameN;
  assign isCfgCmd = (cbeN == CMD_CFG_RD) | (cbeN == CMD_CFG_WR);
  assign cmdIsWrite = (cbeN == CMD_CFG_WR);
  assign isType0 = (adIn[1:0] == TYPE0_CODE);
  assign isFunc0 = (adIn[FUNC_HI:FUNC_LO] == FUNC_ZERO);
  // type 1 or another function never reaches the claim path
  assign claimHit = (state_r == S_IDLE) & addrPhase & idsel & isCfgCmd
                    & isType0 & isFunc0;

  // ---------------------------------------------------------------
  // data phase decode
  // ---------------------------------------------------------------
  wire logic dataDone;
  wire logic cacheWrite;
  // a data phase completes when both ready signals are low
  assign dataDone = (state_r == S_DATA) & ~irdyN & ~trdyN_r;
  // only byte lane 0 of the cache dword is writable
  assign cacheWrite = dataDone & isWrite_r & (dwordIdx_r == DW_CACHE)
                      & ~cbeN[0];

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  wire logic [AD_W-1:0] readWord;
  wire logic [15:0] statusWord;
  wire logic [15:0] commandWord;
  // command bits are not held here, so the word reads zero
  assign commandWord = 16'h0000;
  assign statusWord = STATUS_FIXED;
  // every dword not listed below reads zero, reserved bytes included
  assign readWord =
    (dwordIdx_r == DW_IDENT) ? {PART_CODE, VENDOR_CODE} :
    (dwordIdx_r == DW_CMD_STAT) ? {statusWord, commandWord} :
    (dwordIdx_r == DW_CLASS) ? {FUNC_CLASS_VAL, REVISION_CODE} :
    (dwordIdx_r == DW_CACHE) ? {24'h000000, cacheLine_r} :
    (dwordIdx_r == DW_CAP_HEAD) ? {24'h000000, CAP_HEAD_VAL} :
    (dwordIdx_r == DW_POWER) ?
      {16'h0000, NEXT_LINK_VAL, CAP_TYPE_VAL} :
    {AD_W{1'b0}};

  // ---------------------------------------------------------------
  // cache line setting check
  // ---------------------------------------------------------------
  wire logic [7:0] clLess1;
  wire logic clPow2;
  wire logic clValid;
  assign clLess1 = 8'(cacheLine_r - 8'h01);
  assign clPow2 = ((cacheLine_r & clLess1) == 8'h00);
  // out-of-range or odd sizes would confuse burst sizing downstream
  assign clValid = clPow2 & (cacheLine_r >= CACHE_LINE_MIN)
                   & (cacheLine_r <= CACHE_LINE_MAX);

  // ---------------------------------------------------------------
  // sequencer next state and answers
  // ---------------------------------------------------------------
  // medium decode: devsel low two clocks after the address phase
  always_comb
  begin
    state_nxt = state_r;
    adOut_nxt = adOut_r;
    adOeN_nxt = 1'b1;
    devselN_nxt = 1'b1;
    ctlOeN_nxt = 1'b1;
    trdyN_nxt = 1'b1;
    stopN_nxt = 1'b1;
    case (state_r)
      S_IDLE:
      begin
        if (claimHit)
        begin
          state_nxt = S_DECODE;
        end
      end
      S_DECODE:
      begin
        state_nxt = S_CLAIM;
        devselN_nxt = 1'b0;
        ctlOeN_nxt = 1'b0;
      end
      S_CLAIM:
      begin
        state_nxt = S_DATA;
        devselN_nxt = 1'b0;
        ctlOeN_nxt = 1'b0;
        trdyN_nxt = 1'b0;
        // stop with the first data ends any burst after one dword
        stopN_nxt = 1'b0;
        adOut_nxt = readWord;
        adOeN_nxt = isWrite_r;
      end
      S_DATA:
      begin
        ctlOeN_nxt = 1'b0;
        if (dataDone)
        begin
          state_nxt = S_TURN;
        end
        else
        begin
          devselN_nxt = 1'b0;
          trdyN_nxt = 1'b0;
          stopN_nxt = 1'b0;
          adOeN_nxt = isWrite_r;
        end
      end
      S_TURN:
      begin
        // the frame must be over before a new address phase is seen
        state_nxt = S_IDLE;
      end
      default:
      begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------
  // control pins are driven high for one clock before release
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= S_IDLE;
      devselN_r <= 1'b1;
      ctlOeN_r <= 1'b1;
      trdyN_r <= 1'b1;
      stopN_r <= 1'b1;
      adOeN_r <= 1'b1;
      adOut_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      devselN_r <= devselN_nxt;
      ctlOeN_r <= ctlOeN_nxt;
      trdyN_r <= trdyN_nxt;
      stopN_r <= stopN_nxt;
      adOeN_r <= adOeN_nxt;
      adOut_r <= adOut_nxt;
    end
  end

  // ---------------------------------------------------------------
  // address capture
  // ---------------------------------------------------------------
  // the register index comes from address bits 7:2, 256 bytes total
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      frameNPrev_r <= 1'b1;
      dwordIdx_r <= '0;
      isWrite_r <= 1'b0;
    end
    else
    begin
      frameNPrev_r <= frameN;
      if (claimHit)
      begin
        dwordIdx_r <= adIn[REG_HI:REG_LO];
        isWrite_r <= cmdIsWrite;
      end
    end
  end

  // ---------------------------------------------------------------
  // parity follows the driven data by one clock
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      parOut_r <= 1'b0;
      parOeN_r <= 1'b1;
    end
    else
    begin
      parOut_r <= ^{adOut_r, cbeN};
      parOeN_r <= adOeN_r;
    end
  end

  // ---------------------------------------------------------------
  // cache line length register
  // ---------------------------------------------------------------
  // the raw value is kept and read back; only its use is filtered
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cacheLine_r <= CACHE_LINE_RST;
      cacheLineUse_r <= CACHE_LINE_RST;
    end
    else
    begin
      if (cacheWrite)
      begin
        cacheLine_r <= adIn[7:0];
      end
      cacheLineUse_r <= clValid ? cacheLine_r : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign adOut = adOut_r;
  assign adOeN = adOeN_r;
  assign parOut = parOut_r;
  assign parOeN = parOeN_r;
  assign devselN = devselN_r;
  assign devselOeN = ctlOeN_r;
  assign trdyN = trdyN_r;
  assign trdyOeN = ctlOeN_r;
  assign stopN = stopN_r;
  assign stopOeN = ctlOeN_r;
  assign cacheLineUse = cacheLineUse_r;
endmodule // pcs_config_target

/* logic/pcs_pkg.sv */
// Purpose: constants for the configuration-space target
// Assumes: byte offsets inside the 256-byte configuration space
// Notes: dword indices are taken from the byte offsets
package pcs_pkg;
  // ---------------------------------------------------------------
  // bus widths and command codes
  // ---------------------------------------------------------------
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int DW_IDX_W = 6;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [1:0] TYPE0_CODE = 2'h0;
  localparam logic [2:0] FUNC_ZERO = 3'h0;
  localparam int FUNC_LO = 8;
  localparam int FUNC_HI = 10;
  localparam int REG_LO = 2;
  localparam int REG_HI = 7;

  // ---------------------------------------------------------------
  // byte offsets of the implemented locations and of the header end
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_IDENT = 8'h00;
  localparam logic [7:0] OFF_CMD_STAT = 8'h04;
  localparam logic [7:0] OFF_FUNC_CLASS = 8'h09;
  localparam logic [7:0] OFF_CACHE_LINE = 8'h0C;
  localparam logic [7:0] OFF_CAP_HEAD = 8'h34;
  localparam logic [7:0] OFF_CAP_TYPE = 8'h50;
  localparam logic [7:0] OFF_HEADER_END = 8'h40;
  localparam logic [5:0] DW_IDENT = OFF_IDENT[7:2];
  localparam logic [5:0] DW_CMD_STAT = OFF_CMD_STAT[7:2];
  localparam logic [5:0] DW_CLASS = OFF_FUNC_CLASS[7:2];
  localparam logic [5:0] DW_CACHE = OFF_CACHE_LINE[7:2];
  localparam logic [5:0] DW_CAP_HEAD = OFF_CAP_HEAD[7:2];
  localparam logic [5:0] DW_POWER = OFF_CAP_TYPE[7:2];

  // ---------------------------------------------------------------
  // fixed values and reset values
  // ---------------------------------------------------------------
  localparam logic [23:0] FUNC_CLASS_VAL = 24'h020000;
  localparam logic [7:0] CAP_TYPE_VAL = 8'h01;
  localparam logic [7:0] CAP_HEAD_VAL = OFF_CAP_TYPE;
  localparam logic [7:0] NEXT_LINK_VAL = 8'h00;
  localparam int CAP_LIST_BIT = 4;
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam int DEVSEL_LO = 9;
  localparam logic [15:0] STATUS_FIXED =
    (16'h0001 << CAP_LIST_BIT) | (16'(DEVSEL_MEDIUM) << DEVSEL_LO);
  localparam logic [7:0] CACHE_LINE_RST = 8'h00;
  localparam logic [7:0] CACHE_LINE_MIN = 8'h04;
  localparam logic [7:0] CACHE_LINE_MAX = 8'h40;

  // ---------------------------------------------------------------
  // target sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DECODE = 3'b001,
    S_CLAIM = 3'b010,
    S_DATA = 3'b011,
    S_TURN = 3'b100
  } pcs_state_t;
endpackage

/* testbench/pcs_checker.sv */
// Purpose: bus-level checks of the configuration target
// Assumes: single data phase accesses, one clock domain
// Notes: bound to the target in the bench top file
`timescale 1ns/1ps
module pcs_checker
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host request
  input wire logic frameN,
  input wire logic irdyN,
  input wire logic idsel,
  input wire logic [pcs_pkg::CBE_W-1:0] cbeN,
  input wire logic [pcs_pkg::AD_W-1:0] adIn,
  // target answer
  input wire logic [pcs_pkg::AD_W-1:0] adOut,
  input wire logic adOeN,
  input wire logic parOut,
  input wire logic parOeN,
  input wire logic devselN,
  input wire logic devselOeN,
  input wire logic trdyN,
  input wire logic trdyOeN,
  input wire logic stopN,
  input wire logic stopOeN,
  input wire logic [7:0] cacheLineUse
);
  logic frameQ_r, start, tgt, dataEdge, rdEdge, wrEdge;
  logic [3:0] cmd_r;
  logic [5:0] idx_r;
  logic [7:0] useIn;
  logic parIn;
  // ---------------------------------------------------------------
  // decode of the host side
  // ---------------------------------------------------------------
  // cbeN[3:1] of 101 covers both config read and write
  assign start = !frameN && frameQ_r && idsel && devselOeN && cbeN[3:1] == 3'h5;
  assign tgt = adIn[1:0] == 2'h0 && adIn[10:8] == 3'h0;
  assign dataEdge = !irdyN && !trdyN;
  assign rdEdge = dataEdge && !cmd_r[0];
  assign wrEdge = dataEdge && cmd_r[0];
  assign useIn = adIn[7:0] inside {8'h04, 8'h08, 8'h10, 8'h20, 8'h40} ? adIn[7:0] : 8'h00;
  // even parity over the driven word and the lanes, due one clock later
  assign parIn = ^{adOut, cbeN};
  // command and index held for the data phase
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      frameQ_r <= 1'b0;
      cmd_r <= 4'h0;
      idx_r <= 6'h00;
    end
    else
    begin
      frameQ_r <= frameN;
      if (start)
      begin
        cmd_r <= cbeN;
        idx_r <= adIn[7:2];
      end
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_claim_devsel: assert property (start && tgt |-> ##2 !devselN && !devselOeN)
    else $error("own cycle not claimed two clocks after address");
  a_ignore_other: assert property (start && !tgt |=> devselOeN [*4])
    else $error("foreign cycle was claimed");
  a_one_phase: assert property (dataEdge |=> trdyN && stopN && adOeN ##1 devselOeN)
    else $error("target did not end after one data phase");
  a_use_filter: assert property (wrEdge && idx_r == 6'h03 && !cbeN[0]
    |-> ##2 cacheLineUse == $past(useIn, 2))
    else $error("effective cache line size wrong");
  a_write_ignored: assert property (wrEdge && (idx_r != 6'h03 || cbeN[0])
    |-> ##2 $stable(cacheLineUse))
    else $error("disabled or read-only write changed cache setting");
  a_read_class: assert property (rdEdge && idx_r == 6'h02 |-> adOut[31:8] == 24'h020000)
    else $error("function class wrong");
  a_read_head: assert property (rdEdge && idx_r == 6'h0D |-> adOut == 32'h00000050)
    else $error("capability list head wrong");
  a_read_type: assert property (rdEdge && idx_r == 6'h14 |-> adOut[7:0] == 8'h01)
    else $error("capability type wrong");
  a_status_cap: assert property (rdEdge && idx_r == 6'h01 |-> adOut[20] && !adOeN)
    else $error("capability present bit low");
  a_read_zero: assert property (rdEdge && !(idx_r inside {6'h00, 6'h01, 6'h02, 6'h03,
    6'h0D, 6'h14}) |-> adOut == 32'h00000000)
    else $error("unimplemented location not zero");
  a_read_parity: assert property (!adOeN |=> !parOeN && parOut == $past(parIn))
    else $error("read parity wrong or not driven");
  a_ctl_enables: assert property (trdyOeN == devselOeN && stopOeN == devselOeN
    && (devselN || !devselOeN))
    else $error("control enables disagree");
  c_read: cover property (rdEdge);
  c_write: cover property (wrEdge && idx_r == 6'h03);
  c_ignore: cover property (start && !tgt);
endmodule // pcs_checker

/* testbench/pcs_host_model.sv */
// Purpose: host bridge issuing configuration cycles
// Assumes: requests change on the falling edge of ref_clk
// Notes: AD keeps moving when nobody drives it
`timescale 1ns/1ps
module pcs_host_model
(
  // clock and target answer
  input wire logic ref_clk,
  input wire logic [31:0] adOut,
  input wire logic adOeN,
  input wire logic trdyN,
  // request side
  output logic frameN,
  output logic irdyN,
  output logic idsel,
  output logic [3:0] cbeN,
  output wire logic [31:0] adIn
);
  logic [31:0] hostAd;
  // shared AD wire, target wins while enabled
  assign adIn = adOeN ? hostAd : adOut;
  initial
  begin
    frameN = 1'b1;
    irdyN = 1'b1;
    idsel = 1'b0;
    cbeN = 4'hF;
    hostAd = 32'h0;
  end
  // one access, single data phase; gives up after six clocks
  task automatic access(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
    input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd, output logic hit);
    hit = 1'b0;
    rd = 32'h0;
    @(negedge ref_clk);
    frameN = 1'b0;
    idsel = sel;
    cbeN = cmd;
    hostAd = addr;
    @(negedge ref_clk);
    frameN = 1'b1;
    irdyN = 1'b0;
    idsel = 1'b0;
    cbeN = be;
    hostAd = cmd[0] ? wd : ~addr;
    for (int n = 0; n < 6 && !hit; n++)
    begin
      @(posedge ref_clk);
      hit = !trdyN;
      rd = adIn;
    end
    @(negedge ref_clk);
    irdyN = 1'b1;
    cbeN = 4'hF;
    hostAd = ~hostAd; // stale data must not look valid
    repeat (3) @(negedge ref_clk);
  endtask
endmodule // pcs_host_model

/* testbench/pcs_config_target_bench.sv */
// Purpose: self-checking bench of the configuration target
// Assumes: default identity parameters of the target
// Notes: all traffic goes through the host model task
`timescale 1ns/1ps
module pcs_config_target_bench;
  logic ref_clk, rst, hit;
  wire frameN, irdyN, idsel, adOeN, trdyN;
  wire [3:0] cbeN;
  wire [31:0] adIn, adOut;
  wire [7:0] cacheLineUse;
  logic [31:0] rd;
  logic [7:0] v;
  int errCount, testsRun;
  logic [7:0] vals [6] = '{8'h04, 8'h40, 8'h20, 8'h03, 8'h80, 8'h0C};
  pcs_config_target uut (.ref_clk, .rst, .frameN, .irdyN, .idsel, .cbeN, .adIn, .adOut,
    .adOeN, .parOut(), .parOeN(), .devselN(), .devselOeN(), .trdyN, .trdyOeN(), .stopN(),
    .stopOeN(), .cacheLineUse);
  pcs_host_model host (.ref_clk, .adOut, .adOeN, .trdyN, .frameN, .irdyN, .idsel, .cbeN,
    .adIn);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // claimed access; a missing claim ends the run
  task automatic acc(input logic [3:0] cmd, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] wd, input logic [31:0] exp);
    host.access(cmd, {24'h0, a}, 1'b1, be, wd, rd, hit);
    check({31'h0, hit}, 32'h1);
    if (hit !== 1'b1)
      results();
    if (!cmd[0])
      check(rd, exp);
  endtask
  // foreign cycle must stay unanswered
  task automatic miss(input logic [3:0] cmd, input logic [31:0] a, input logic sel);
    host.access(cmd, a, sel, 4'h0, 32'h00000099, rd, hit);
    check({31'h0, hit}, 32'h0);
  endtask
  task automatic results();
    if (errCount == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    errCount = 0;
    testsRun = 0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check(cacheLineUse, 32'h0);
    acc(4'hA, 8'h0C, 4'h0, 0, 32'h0);
    acc(4'hA, 8'h08, 4'h0, 0, 32'h02000001);
    acc(4'hA, 8'h34, 4'hF, 0, 32'h00000050);
    acc(4'hA, 8'h50, 4'h0, 0, 32'h00000001);
    acc(4'hA, 8'h04, 4'h0, 0, 32'h02100000);
    acc(4'hA, 8'h00, 4'h0, 0, 32'h0A0A1D1D);
    acc(4'hA, 8'h40, 4'h0, 0, 32'h0);
    acc(4'hA, 8'hFC, 4'h0, 0, 32'h0);
    // upper lanes of 0x0C are read-only, so they must stay zero
    foreach (vals[i])
    begin
      v = vals[i];
      acc(4'hB, 8'h0C, 4'h0, {24'hABCDEF, v}, 0);
      acc(4'hA, 8'h0C, 4'h0, 0, {24'h0, v});
      check(cacheLineUse, v inside {8'h04, 8'h08, 8'h10, 8'h20, 8'h40} ? v : 8'h00);
    end
    acc(4'hB, 8'h0C, 4'h1, 32'h00000010, 0);
    acc(4'hA, 8'h0C, 4'h0, 0, 32'h0000000C);
    acc(4'hB, 8'h08, 4'h0, 32'hFFFFFFFF, 0);
    acc(4'hA, 8'h08, 4'h0, 0, 32'h02000001);
    miss(4'hB, 32'h0000000D, 1'b1);
    miss(4'hB, 32'h0000010C, 1'b1);
    miss(4'hA, 32'h0000000C, 1'b0);
    acc(4'hA, 8'h0C, 4'h0, 0, 32'h0000000C);
    // a reset in mid-run must bring the stored size back to zero
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check(cacheLineUse, 32'h0);
    acc(4'hA, 8'h0C, 4'h0, 0, 32'h0);
    results();
  end
endmodule // pcs_config_target_bench
bind pcs_config_target pcs_checker chk (.ref_clk, .rst, .frameN, .irdyN, .idsel, .cbeN,
  .adIn, .adOut, .adOeN, .parOut, .parOeN, .devselN, .devselOeN, .trdyN, .trdyOeN, .stopN,
  .stopOeN, .cacheLineUse);
